// ### hdl/ser_pkg.sv
/*
 Shared constants and carriers for the status and event reporting block:
 status byte and event latch bit positions, mask presets, queue sizes,
 host command and internal event structs, and the control-takeover states.
 Assumes one system clock and a power-on reset elsewhere in the device.
*/
// Overview of operation
// - Status bit 3 is high while any enabled questionable event is true.
// - Status bit 4 is high while the output response queue holds data.
// - Bit 4 follows only the queue; status reads and clear-status leave it.
// - Status bit 5 is high when any enabled standard event bit is set.
// - Standard event bits latch until read; the read clears all, then bit 5.
// - Status bit 6 summarises enabled status bits and drives the service request line.
// - Status bit 7 is high while the instrument waits for a trigger.
// - The event latch clears on its read query or silently on clear-status.
// - Event bits 7..0: power-on, user, command, execution, device, query, control, complete.
// - Event bit 0 sets each time an operation completes.
// - With scope capture on, set bit 1, take control, fetch, pass control back.
// - Event bit 2 sets on any query fault.
// - Event bit 3 sets on an internal fault unrelated to command execution.
// - Event bit 4 sets when a command carries an invalid parameter.
// - Event bit 5 sets when command parsing fails.
// - Remote panel hardcopy with bus destination sets bit 6 instead of printing.
// - Event bit 7 sets after power comes on.
// - A mask write takes the decimal weight sum as the plain bit pattern.
// - Error queue holds three codes; status bit 2 high while not empty.
// - Reading the status byte changes none of its bits.
// - Reset and clear-status leave masks alone; power-on loads their presets.
package ser_pkg;
   // ==================================================
   // widths and sizes
   localparam int unsigned SER_BYTE_W = 8;
   localparam int unsigned SER_QUES_W = 15;
   localparam int unsigned SER_ERR_W  = 8;
   localparam int unsigned SER_ERRQ_D = 3;
   // ==================================================
   // status byte bit positions
   localparam int unsigned STB_ERRQ = 2;
   localparam int unsigned STB_QUES = 3;
   localparam int unsigned STB_MAV  = 4;
   localparam int unsigned STB_ESB  = 5;
   localparam int unsigned STB_RQS  = 6;
   localparam int unsigned STB_OPER = 7;
   // ==================================================
   // standard event latch bit positions
   localparam int unsigned EVB_OPC = 0;
   localparam int unsigned EVB_RQC = 1;
   localparam int unsigned EVB_QYE = 2;
   localparam int unsigned EVB_DDE = 3;
   localparam int unsigned EVB_EXE = 4;
   localparam int unsigned EVB_CME = 5;
   localparam int unsigned EVB_URQ = 6;
   localparam int unsigned EVB_PON = 7;
   // ==================================================
   // reset and preset values
   localparam logic [7:0] SER_ZERO8      = 8'h00;
   localparam logic [7:0] EVT_MASK_PRE   = 8'h00;
   localparam logic [7:0] SRQ_MASK_PRE   = 8'h00;
   localparam logic [7:0] SRQ_MASK_VALID = 8'hbf; // position 6 is never an input
   // ==================================================
   // host commands, one-cycle strobes, at most one per cycle
   typedef struct packed {
      logic       stb_rd;   // status byte query or serial poll
      logic       esr_rd;   // event latch read and clear
      logic       cls;      // clear status
      logic       rst;      // device reset
      logic       ese_wr;
      logic       sre_wr;
      logic       ese_rd;
      logic       sre_rd;
      logic       err_rd;   // pop one error code
      logic [7:0] wdata;
   } ser_cmd_s;
   // internal event strobes from the command engine
   typedef struct packed {
      logic op_done;
      logic query_fault;
      logic dev_fault;
      logic bad_param;
      logic parse_fail;
   } ser_evt_s;
   // control takeover for scope capture
   typedef enum logic [1:0] {CTL_IDLE, CTL_ASK, CTL_OWN, CTL_GIVE} ser_ctl_e;
endpackage

// ### hdl/ser_evlatch.sv
/*
 Eight sticky event flags with a common clear.
 Assumes set and clear are strobes on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module ser_evlatch
   import ser_pkg::*;
(
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst_b,
   // control
   input  wire logic [7:0] set,
   input  wire logic       clr,
   // state
   output logic      [7:0] flags
);
   // an event in the clearing cycle survives: set wins over clear
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         flags <= SER_ZERO8;
      end else begin
         flags <= (clr ? SER_ZERO8 : flags) | set;
      end
   end
endmodule
`default_nettype wire

// ### hdl/ser_errq.sv
/*
 Small error code queue, head at slot 0.
 Assumes push, pop and flush are same-clock strobes; a push into a full
 queue is dropped so the oldest codes stay readable.
*/
`timescale 1ns/1ps
`default_nettype none
module ser_errq
   import ser_pkg::*;
(
   // clock and reset
   input  wire logic                 clk,
   input  wire logic                 rst_b,
   // requests
   input  wire logic                 push,
   input  wire logic [SER_ERR_W-1:0] code,
   input  wire logic                 pop,
   input  wire logic                 flush,
   // state
   output logic      [SER_ERR_W-1:0] head,
   output logic                      not_empty
);
   logic [SER_ERR_W-1:0] slot [SER_ERRQ_D];
   logic [1:0]           cnt_reg;
   logic [1:0]           base;
   logic                 do_pop;

   assign do_pop    = pop && (cnt_reg != 2'h0);
   assign base      = do_pop ? cnt_reg - 2'h1 : cnt_reg;
   assign head      = slot[0];
   assign not_empty = (cnt_reg != 2'h0);

   // shift on pop, then append behind the remaining codes
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_reg <= 2'h0;
         for (int i = 0; i < SER_ERRQ_D; i++) slot[i] <= SER_ZERO8;
      end else if (flush) begin
         cnt_reg <= 2'h0;
      end else begin
         if (do_pop) begin
            for (int i = 0; i < SER_ERRQ_D - 1; i++) slot[i] <= slot[i+1];
         end
         if (push && base < 2'(SER_ERRQ_D)) begin
            slot[base] <= code;
            cnt_reg    <= base + 2'h1;
         end else begin
            cnt_reg    <= base;
         end
      end
   end
endmodule
`default_nettype wire

// ### hdl/ser_top.sv
/*
 Status and event reporting: status byte, standard event latch with its
 mask, service request mask and line, control takeover for scope capture
 and the panel hardcopy interlock.
 Assumes the bus interface and command parser run on CLK and decode host
 commands into the CMD strobes; every input is already in this domain.
*/
`timescale 1ns/1ps
`default_nettype none
module ser_top
   import ser_pkg::*;
(
   // clock and reset
   input  wire logic                  CLK,
   input  wire logic                  RST_B,
   // host commands and answers
   input  wire ser_pkg::ser_cmd_s     CMD,
   output logic                       RSP_VALID,
   output logic      [7:0]            RSP_DATA,
   // internal events and conditions
   input  wire ser_pkg::ser_evt_s     EVT,
   input  wire logic                  OUTQ_NOT_EMPTY,
   input  wire logic [14:0]           QUES_EVENT,
   input  wire logic [14:0]           QUES_ENABLE,
   input  wire logic                  WAIT_TRIG,
   input  wire logic                  ERR_PUSH,
   input  wire logic [7:0]            ERR_CODE,
   // control takeover
   input  wire logic                  SCOPE_CAPTURE_CONTROL_SETTING,
   input  wire logic                  CAPTURE_START,
   input  wire logic                  CONTROL_GRANTED,
   input  wire logic                  CAPTURE_DONE,
   output logic                       CONTROLLER_ACTIVE,
   output logic                       CONTROL_RETURN,
   // hardcopy
   input  wire logic                  REMOTE_ACTIVE,
   input  wire logic                  HCOPY_TO_BUS,
   input  wire logic                  PANEL_HCOPY_REQ,
   output logic                       HCOPY_START,
   // status outputs
   output logic      [7:0]            STATUS_BYTE,
   output logic                       SRQ_OE
);
   import ser_pkg::*;

   // ==================================================
   // declarations
   logic [7:0]           evt_mask_reg;
   logic [7:0]           srq_mask_reg;
   logic [7:0]           stb_reg;
   logic [7:0]           stb_next;
   logic                 srq_reg;
   logic [7:0]           ev_flags;
   logic [7:0]           ev_set;
   logic                 ev_clr;
   logic [SER_ERR_W-1:0] err_head;
   logic                 err_ne;
   logic                 pon_reg;
   logic                 rsp_valid_reg;
   logic [7:0]           rsp_data_reg;
   ser_ctl_e             ctl_reg;
   ser_ctl_e             ctl_next;
   logic                 ctl_act_reg;
   logic                 ctl_ret_reg;
   logic                 hc_start_reg;
   logic                 hc_defer;
   logic                 ask_ctl;
   logic                 up_reg;

   // true when any bit of a against mask b is set
   function automatic logic any_hit(input logic [7:0] a, input logic [7:0] b);
      return |(a & b);
   endfunction

   // ==================================================
   // power-on event
   // pon_reg is a constant at reset and drops after one edge, so the
   // power-on flag is raised exactly once per off-to-on transition
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         pon_reg <= 1'b1;
      end else begin
         pon_reg <= 1'b0;
      end
   end

   // helper for checks: high from the first edge after release
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         up_reg <= 1'b0;
      end else begin
         up_reg <= 1'b1;
      end
   end

   // ==================================================
   // enable masks
   // only power-on loads the presets; reset and clear-status leave them
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         evt_mask_reg <= EVT_MASK_PRE;
         srq_mask_reg <= SRQ_MASK_PRE;
      end else begin
         if (CMD.ese_wr) begin
            evt_mask_reg <= CMD.wdata;
         end
         if (CMD.sre_wr) begin
            srq_mask_reg <= CMD.wdata & SRQ_MASK_VALID;
         end
      end
   end

   // ==================================================
   // standard event latch
   // hardcopy held back only under remote control with the bus as sink
   assign hc_defer = PANEL_HCOPY_REQ && REMOTE_ACTIVE && HCOPY_TO_BUS;
   assign ask_ctl  = (ctl_reg == CTL_IDLE) && SCOPE_CAPTURE_CONTROL_SETTING && CAPTURE_START;

   // event sources mapped onto their positions
   always_comb begin
      ev_set          = SER_ZERO8;
      ev_set[EVB_OPC] = EVT.op_done;
      ev_set[EVB_RQC] = ask_ctl;
      ev_set[EVB_QYE] = EVT.query_fault;
      ev_set[EVB_DDE] = EVT.dev_fault;
      ev_set[EVB_EXE] = EVT.bad_param;
      ev_set[EVB_CME] = EVT.parse_fail;
      ev_set[EVB_URQ] = hc_defer;
      ev_set[EVB_PON] = pon_reg;
   end

   // a read query or clear-status empties the latch
   assign ev_clr = CMD.esr_rd || CMD.cls;

   ser_evlatch u_evlatch (
      .clk   (CLK),
      .rst_b (RST_B),
      .set   (ev_set),
      .clr   (ev_clr),
      .flags (ev_flags)
   );

   // ==================================================
   // error queue, flushed by clear-status
   ser_errq u_errq (
      .clk       (CLK),
      .rst_b     (RST_B),
      .push      (ERR_PUSH),
      .code      (ERR_CODE),
      .pop       (CMD.err_rd),
      .flush     (CMD.cls),
      .head      (err_head),
      .not_empty (err_ne)
   );

   // ==================================================
   // status byte
   // every bit is a live summary of its source, so a status read has
   // nothing to clear; summaries lag their sources by one edge
   always_comb begin
      stb_next           = SER_ZERO8;
      stb_next[STB_ERRQ] = err_ne;
      stb_next[STB_QUES] = |(QUES_EVENT & QUES_ENABLE);
      stb_next[STB_MAV]  = OUTQ_NOT_EMPTY;
      stb_next[STB_ESB]  = any_hit(ev_flags, evt_mask_reg);
      stb_next[STB_OPER] = WAIT_TRIG;
      stb_next[STB_RQS]  = any_hit(stb_next, srq_mask_reg);
   end

   // status byte and service request line share one edge
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         stb_reg <= SER_ZERO8;
         srq_reg <= 1'b0;
      end else begin
         stb_reg <= stb_next;
         srq_reg <= stb_next[STB_RQS];
      end
   end

   // ==================================================
   // host answers
   // one command per cycle; the answer appears on the next edge
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         rsp_valid_reg <= 1'b0;
         rsp_data_reg  <= SER_ZERO8;
      end else begin
         rsp_valid_reg <= CMD.stb_rd || CMD.esr_rd || CMD.ese_rd || CMD.sre_rd || CMD.err_rd;
         if (CMD.stb_rd) begin
            rsp_data_reg <= stb_reg;
         end else if (CMD.esr_rd) begin
            rsp_data_reg <= ev_flags;
         end else if (CMD.ese_rd) begin
            rsp_data_reg <= evt_mask_reg;
         end else if (CMD.sre_rd) begin
            rsp_data_reg <= srq_mask_reg;
         end else if (CMD.err_rd) begin
            rsp_data_reg <= err_ne ? err_head : SER_ZERO8;
         end
      end
   end

   // ==================================================
   // control takeover for scope capture
   // the host must yield control; we wait in CTL_ASK until it does, the capture setting is cleared or a device reset comes
   always_comb begin
      ctl_next = ctl_reg;
      unique case (ctl_reg)
         CTL_IDLE: begin
            if (ask_ctl) ctl_next = CTL_ASK;
         end
         CTL_ASK: begin
            if (!SCOPE_CAPTURE_CONTROL_SETTING) ctl_next = CTL_IDLE;
            else if (CONTROL_GRANTED) ctl_next = CTL_OWN;
         end
         CTL_OWN: begin
            if (CAPTURE_DONE) ctl_next = CTL_GIVE;
         end
         CTL_GIVE: begin
            ctl_next = CTL_IDLE;
         end
      endcase
      if (CMD.rst) ctl_next = CTL_IDLE;
   end

   // state and registered controller outputs
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         ctl_reg     <= CTL_IDLE;
         ctl_act_reg <= 1'b0;
         ctl_ret_reg <= 1'b0;
      end else begin
         ctl_reg     <= ctl_next;
         ctl_act_reg <= (ctl_next == CTL_OWN);
         ctl_ret_reg <= (ctl_next == CTL_GIVE);
      end
   end

   // ==================================================
   // hardcopy start
   // a bus hardcopy would drop into talk-only and break the session
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         hc_start_reg <= 1'b0;
      end else begin
         hc_start_reg <= PANEL_HCOPY_REQ && !hc_defer;
      end
   end

   // ==================================================
   // outputs
   assign STATUS_BYTE       = stb_reg;
   assign SRQ_OE            = srq_reg;
   assign RSP_VALID         = rsp_valid_reg;
   assign RSP_DATA          = rsp_data_reg;
   assign CONTROLLER_ACTIVE = ctl_act_reg;
   assign CONTROL_RETURN    = ctl_ret_reg;
   assign HCOPY_START       = hc_start_reg;

   // ==================================================
   // checks
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_B);

   sequence grant_seq;
      ctl_reg == CTL_ASK && SCOPE_CAPTURE_CONTROL_SETTING && CONTROL_GRANTED && !CMD.rst;
   endsequence
   sequence own_seq;
      CONTROLLER_ACTIVE && !CONTROL_RETURN;
   endsequence
   sequence done_seq;
      ctl_reg == CTL_OWN && CAPTURE_DONE && !CMD.rst;
   endsequence
   sequence give_seq;
      CONTROL_RETURN && !CONTROLLER_ACTIVE ##1 !CONTROL_RETURN;
   endsequence

   ctl_take_a: assert property (grant_seq |=> own_seq)
      else $error("control not taken after grant");
   ctl_back_a: assert property (done_seq |=> give_seq)
      else $error("control not passed back after capture");
   rqc_flag_a: assert property (ask_ctl && !CMD.rst |=> ev_flags[EVB_RQC] && ctl_reg == CTL_ASK)
      else $error("request control flag missing");
   stb_low_a: assert property (STATUS_BYTE[1:0] == 2'h0)
      else $error("status bits 1:0 not zero");
   mav_follow_a: assert property (up_reg |-> STATUS_BYTE[STB_MAV] == $past(OUTQ_NOT_EMPTY))
      else $error("data pending bit does not follow queue");
   mav_read_a: assert property (up_reg && (CMD.stb_rd || CMD.cls) && OUTQ_NOT_EMPTY
                                |=> STATUS_BYTE[STB_MAV])
      else $error("data pending bit changed by read or clear");
   ques_sum_a: assert property (up_reg |-> STATUS_BYTE[STB_QUES] == $past(|(QUES_EVENT & QUES_ENABLE)))
      else $error("questionable summary wrong");
   oper_sum_a: assert property (up_reg |-> STATUS_BYTE[STB_OPER] == $past(WAIT_TRIG))
      else $error("operation summary wrong");
   esb_sum_a: assert property (any_hit(ev_flags, evt_mask_reg) |=> STATUS_BYTE[STB_ESB])
      else $error("event summary not set");
   esr_clear_a: assert property (CMD.esr_rd && ev_set == SER_ZERO8
                                 |=> ev_flags == SER_ZERO8 ##1 !STATUS_BYTE[STB_ESB])
      else $error("event latch not cleared by read");
   esr_answer_a: assert property (CMD.esr_rd |=> RSP_VALID && RSP_DATA == $past(ev_flags))
      else $error("event latch read returned wrong value");
   cls_clear_a: assert property (CMD.cls && !CMD.esr_rd && ev_set == SER_ZERO8
                                 |=> ev_flags == SER_ZERO8 && !RSP_VALID)
      else $error("clear-status did not clear latch silently");
   set_wins_a: assert property (ev_clr && EVT.op_done |=> ev_flags[EVB_OPC])
      else $error("completion lost in clearing cycle");
   fault_map_a: assert property (EVT.query_fault || EVT.dev_fault || EVT.bad_param || EVT.parse_fail
                                 |=> (ev_flags[5:2] & $past({EVT.parse_fail, EVT.bad_param,
                                      EVT.dev_fault, EVT.query_fault})) == $past({EVT.parse_fail,
                                      EVT.bad_param, EVT.dev_fault, EVT.query_fault}))
      else $error("fault event not latched at its position");
   hc_defer_a: assert property (hc_defer |=> ev_flags[EVB_URQ] && !HCOPY_START)
      else $error("remote hardcopy not deferred");
   pon_once_a: assert property (!up_reg |=> ev_flags[EVB_PON])
      else $error("power-on flag not raised");
   srq_rqs_a: assert property (up_reg |-> SRQ_OE == STATUS_BYTE[STB_RQS] &&
                               SRQ_OE == any_hit(STATUS_BYTE & SRQ_MASK_VALID, $past(srq_mask_reg)))
      else $error("service request line disagrees with status");
   rqs_sum_a: assert property (up_reg |-> STATUS_BYTE[STB_RQS] ==
                               any_hit({$past(stb_next[7]), 1'b0, $past(stb_next[5:0])}, $past(srq_mask_reg)))
      else $error("service request summary wrong");
   mask_keep_a: assert property ((CMD.cls || CMD.rst) && !CMD.ese_wr && !CMD.sre_wr
                                 |=> $stable(evt_mask_reg) && $stable(srq_mask_reg))
      else $error("mask changed by reset or clear");
   mask_wr_a: assert property (CMD.ese_wr |=> evt_mask_reg == $past(CMD.wdata))
      else $error("event mask write not stored as weights");
   errq_bit_a: assert property (up_reg |-> STATUS_BYTE[STB_ERRQ] == $past(err_ne))
      else $error("error queue bit wrong");
   stb_read_a: assert property (CMD.stb_rd |=> RSP_DATA == $past(STATUS_BYTE) && RSP_VALID)
      else $error("status read answer wrong");
endmodule
`default_nettype wire

// ### sim/ser_host_model.sv
/*
 Remote host model: hands bus control over some cycles after it sees a
 service request and takes it back when the device returns it.
 Assumes SRQ_OE of ser_top is the service request line.
*/
`timescale 1ns/1ps
`default_nettype none
module ser_host_model (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst_b,
   // bus view
   input  wire logic       srq_oe,
   input  wire logic       ctl_active,
   input  wire logic       ctl_return,
   input  wire logic [3:0] dly,
   // control handed to the device
   output logic            grant
);
   // ==========
   // pass-control handling
   logic [3:0] cnt_reg;
   // grant drops once no request stands, so a stale grant never meets a new ask
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         grant   <= 1'b0;
         cnt_reg <= 4'h0;
      end else if (ctl_return || (!srq_oe && !ctl_active)) begin
         grant   <= 1'b0;
         cnt_reg <= 4'h0;
      end else if (srq_oe && !grant) begin
         if (cnt_reg == dly) grant <= 1'b1;
         else cnt_reg <= cnt_reg + 4'h1;
      end
   end
endmodule
`default_nettype wire

// ### sim/status_event_reporting_tb.sv
/*
 Bench for ser_top: random host traffic against a status model, plus
 takeover and hardcopy corners. Assumes ser_host_model as remote host.
*/
`timescale 1ns/1ps
`default_nettype none
module status_event_reporting_tb;
   import ser_pkg::*;
   // ==========
   // stimulus and model state
   localparam int B_STB = 16, B_ESR = 15, B_CLS = 14, B_RST = 13, B_ESEW = 12;
   localparam int B_SREW = 11, B_ESER = 10, B_SRER = 9, B_ERR = 8;
   logic        clk, rst_b, oq, wt, epush, scope, cstart, cdone, remote, tobus, panel;
   logic        rsp_valid, act, ret, hstart, srq_oe, grant, hs;
   logic [7:0]  ecode, rsp_data, stb, lat, standard_event_mask, service_request_mask;
   logic [14:0] qe, qen;
   logic [3:0]  dly;
   ser_cmd_s    cmd;
   ser_evt_s    evt;
   logic [7:0]  eq[$];
   int          err_total, n_compared;
   ser_top u_ser_top (.CLK(clk), .RST_B(rst_b), .CMD(cmd), .RSP_VALID(rsp_valid), .RSP_DATA(rsp_data),
      .EVT(evt), .OUTQ_NOT_EMPTY(oq), .QUES_EVENT(qe), .QUES_ENABLE(qen), .WAIT_TRIG(wt), .ERR_PUSH(epush),
      .ERR_CODE(ecode), .SCOPE_CAPTURE_CONTROL_SETTING(scope), .CAPTURE_START(cstart), .CONTROL_GRANTED(grant),
      .CAPTURE_DONE(cdone), .CONTROLLER_ACTIVE(act), .CONTROL_RETURN(ret), .REMOTE_ACTIVE(remote),
      .HCOPY_TO_BUS(tobus), .PANEL_HCOPY_REQ(panel), .HCOPY_START(hstart), .STATUS_BYTE(stb), .SRQ_OE(srq_oe));
   ser_host_model u_ser_host_model (.clk(clk), .rst_b(rst_b), .srq_oe(srq_oe), .ctl_active(act),
      .ctl_return(ret), .dly(dly), .grant(grant));
   // ==========
   // expectations
   function automatic logic [7:0] f_stb();
      logic [7:0] s;
      s = {wt, 1'b0, |(lat & standard_event_mask), oq, |(qe & qen), eq.size() != 0, 2'b00};
      s[6] = |(s & service_request_mask);
      return s;
   endfunction
   task automatic chk8(string n, logic [7:0] e, logic [7:0] g);
      n_compared++;
      if (g !== e) begin
         err_total++;
         $display("[FAIL] %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic chk1(string n, logic e, logic g);
      n_compared++;
      if (g !== e) begin
         err_total++;
         $display("[FAIL] %s exp %b got %b", n, e, g);
      end
   endtask
   // one command strobe; reads wait a bounded time for the answer, model follows
   task automatic op(int b, logic [7:0] d, logic [7:0] e);
      cmd = ser_cmd_s'(17'((17'h1 << b) | {9'h0, d}));
      @(negedge clk);
      cmd = '0;
      if (b == B_ESEW) standard_event_mask = d;
      if (b == B_SREW) service_request_mask = d & SRQ_MASK_VALID;
      if (b == B_CLS || b == B_ESR) lat = 8'h00;
      if (b == B_CLS) eq.delete();
      if (b == B_ERR && eq.size() != 0) void'(eq.pop_front());
      if (b inside {B_STB, B_ESR, B_ESER, B_SRER, B_ERR}) begin
         for (int k = 0; k < 3 && rsp_valid !== 1'b1; k++) @(negedge clk);
         chk1("rsp_valid", 1'b1, rsp_valid);
         chk8($sformatf("answer %0d", b), e, rsp_data);
      end
      // idle cycle, so the next strobe is not driven in the same step as the clear
      @(negedge clk);
   endtask
   // summaries lag their sources by up to two edges
   task automatic settle();
      logic [7:0] s;
      repeat (3) @(negedge clk);
      s = f_stb();
      chk8("status", s, stb);
      chk1("srq", s[6], srq_oe);
   endtask
   task automatic takeover(logic [3:0] d);
      dly = d;
      // service request mask first, so a grant left from the random phase drops before the ask
      op(B_SREW, 8'h20, 8'h00);
      op(B_CLS, 8'h00, 8'h00);
      op(B_ESEW, 8'h02, 8'h00);
      scope = 1'b1;
      cstart = 1'b1;
      @(negedge clk);
      cstart = 1'b0;
      lat[1] = 1'b1;
      for (int k = 0; k < 40 && act !== 1'b1; k++) @(negedge clk);
      chk1("active", 1'b1, act);
      settle();
      cdone = 1'b1;
      @(negedge clk);
      cdone = 1'b0;
      for (int k = 0; k < 3 && ret !== 1'b1; k++) @(negedge clk);
      chk1("return", 1'b1, ret);
      @(negedge clk);
      chk1("released", 1'b0, act | ret);
      scope = 1'b0;
      op(B_ESR, 8'h00, 8'h02);
      settle();
   endtask
   task automatic wrap_up();
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // ==========
   // clock, watchdog and main sequence
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // the tests need under two thousand cycles; a hang is cut well after that
   initial begin
      repeat (50000) @(posedge clk);
      err_total++;
      wrap_up();
   end
   initial begin
      {rst_b, oq, wt, epush, scope, cstart, cdone, remote, tobus, panel} = '0;
      {ecode, qe, qen, dly, standard_event_mask, service_request_mask} = '0;
      cmd = '0;
      evt = '0;
      lat = 8'h80;
      err_total = 0;
      n_compared = 0;
      void'($urandom(94403));
      repeat (20) @(posedge clk);
      @(negedge clk);
      rst_b = 1'b1;
      settle();
      op(B_ESER, 8'h00, EVT_MASK_PRE);
      op(B_SRER, 8'h00, SRQ_MASK_PRE);
      op(B_ESR, 8'h00, 8'h80);
      op(B_ESEW, 8'h01, 8'h00);
      repeat (300) begin
         case ($urandom % 13)
            0: op(B_ESEW, 8'($urandom), 8'h00);
            1: op(B_SREW, 8'($urandom), 8'h00);
            2: op(B_ESR, 8'h00, lat);
            3: op(B_CLS, 8'h00, 8'h00);
            4: op(B_ERR, 8'h00, eq.size() != 0 ? eq[0] : 8'h00);
            5: op(B_STB, 8'h00, f_stb());
            6: op(B_ESER, 8'h00, standard_event_mask);
            7: op(B_SRER, 8'h00, service_request_mask);
            8: op(B_RST, 8'h00, 8'h00);
            default: begin
               evt = ser_evt_s'(5'($urandom));
               {oq, wt, epush} = 3'($urandom);
               {ecode, qe, qen} = 38'({$urandom, $urandom});
               lat |= {2'b00, evt.parse_fail, evt.bad_param, evt.dev_fault, evt.query_fault, 1'b0, evt.op_done};
               if (epush && eq.size() < 3) eq.push_back(ecode);
               @(negedge clk);
               evt = '0;
               epush = 1'b0;
            end
         endcase
         settle();
      end
      // completion in the very cycle of the read: the new flag must survive the clear
      evt.op_done = 1'b1;
      op(B_ESR, 8'h00, lat);
      evt = '0;
      lat = 8'h01;
      op(B_ESR, 8'h00, 8'h01);
      takeover(4'h0);
      takeover(4'h6);
      // all four hardcopy routings; only remote-to-bus is diverted to the latch
      for (int i = 0; i < 4; i++) begin
         {remote, tobus} = 2'(i);
         panel = 1'b1;
         @(negedge clk);
         panel = 1'b0;
         hs = hstart;
         @(negedge clk);
         hs = hs | hstart;
         if (i == 3) lat[6] = 1'b1;
         chk1("hcopy", i != 3, hs);
         settle();
      end
      op(B_ESR, 8'h00, lat);
      wrap_up();
   end
endmodule
`default_nettype wire
